// ---- core/effective_address_decoder.sv ----
// effective address decoder with an AXI4-Lite register front end
// assumes a single aclk domain; software loads operands and reads results
// Function
// - codes 00-07 pick byte, word or long register; long uses code over two
// - register form takes 00-07, memory form 08-1F always gives a memory address
// - codes 0C-0F use word registers 0-3, post-increment pointer, no extension
// - codes 10-17 add 8-bit displacement, one byte; 08-0B plain pointers
// - codes 18-1B add 16-bit displacement held in two extension bytes
// - codes 1C, 1D index word register 0 or 1 by register seven
// - code 1E is counter plus 16-bit displacement, 1F direct; two bytes
// - instruction length is base bytes plus extension bytes of the code
// - mode cycles 1 plain, 4 post-increment, 2 indexed and counter-relative
// - actual cycles are base cycles plus mode cycles plus correction
// - register and even RAM add none; odd RAM adds 0, 1, 2
// - even external adds 1,1,2; odd or narrow bus adds 1,3,6
// - accumulator used as byte, low word, or both words by width
// - byte loads zero or sign-extend accumulator bits 15 to 8
// - upper word copies old low, clears, or sign-extends low word
// - each flag follows result, stays, is set or is cleared
// - short io form reaches 000000-0000FF only; short immediate sign-extends
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module effective_address_decoder (
    input  wire logic        aclk,           // machine clock, 200 MHz
    input  wire logic        aresetn,        // synchronous reset, active low
    input  wire logic [7:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write byte strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [7:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready,   // read data ready
    input  wire logic [7:0]  data_bank,      // bank for memory addresses
    input  wire logic [15:0] program_counter,// program counter of the instruction
    output logic [23:0]      operand_address,// registered memory address
    output logic             stall_request   // high while cycles remain
);
    import ea_decoder_pkg::*;

    // ========================================================
    // software registers
    logic [REQUEST_BITS-1:0] request_reg;
    logic [31:0]             operand_reg;    // byte loaded, or low word result source
    logic [31:0]             pointer_reg;    // [15:0] selected word reg, [31:16] register seven
    logic [31:0]             disp_reg;       // [15:0] displacement, [23:16] short immediate
    logic [31:0]             acc_reg;        // accumulator before instruction
    logic [31:0]             flags_reg;      // [13:0] actions, [20:14] old, [27:21] result

    // decode snapshot
    logic [23:0]             address_reg;
    logic [31:0]             acc_out_reg;
    logic [15:0]             ptr_out_reg;
    logic [7:0]              counts_reg;     // total cycles
    logic [3:0]              length_reg;
    logic [6:0]              flags_out_reg;
    logic                    mem_flag_reg;
    logic                    form_err_reg;

    // countdown and strobe
    logic [7:0]              stall_reg;
    logic                    go_reg;

    // ========================================================
    // request field selection
    wire  [4:0] code        = request_reg[CODE_LSB +: 5];
    wire  [1:0] width       = request_reg[WIDTH_LSB +: 2];
    wire  [2:0] location    = request_reg[LOCATION_LSB +: 3];
    wire  [3:0] base_cycles = request_reg[BASE_LSB +: 4];
    wire  [2:0] base_bytes  = request_reg[BASE_LEN_LSB +: 3];
    wire  [1:0] low_act     = request_reg[LOW_ACT_LSB +: 2];
    wire  [1:0] up_act      = request_reg[UPPER_ACT_LSB +: 2];
    wire        reg_form    = request_reg[FORM_LSB];

    // mode classification by code range
    wire is_reg_direct = (code <= CODE_REG_LAST);
    wire is_plain_ind  = !is_reg_direct && (code <= CODE_IND_LAST);
    wire is_post_inc   = (code > CODE_IND_LAST) && (code <= CODE_POST_LAST);
    wire is_short_displacement      = (code > CODE_POST_LAST) && (code <= CODE_D8_LAST);
    wire is_long_displacement     = (code > CODE_D8_LAST) && (code <= CODE_D16_LAST);
    wire is_indexed    = (code == CODE_IDX0) || (code == CODE_IDX1);
    wire is_pc_rel     = (code == CODE_PC_REL);
    wire is_direct     = (code == CODE_DIRECT);

    // register form only takes 00-07; memory form only 08-1F
    wire form_error    = reg_form ? !is_reg_direct : is_reg_direct;

    // register number presented to the register file
    wire [2:0] reg_number  = (width == 2'(WIDTH_LONG)) ? {1'b0, code[2:1]} : code[2:0];

    // extension bytes and addressing cycles
    wire [2:0] ext_bytes = is_short_displacement ? EXT_ONE :
                           (is_long_displacement || is_pc_rel || is_direct) ? EXT_TWO :
                           EXT_NONE;

    wire [3:0] mode_cycles = is_reg_direct ? 4'h0 :
                             is_post_inc ? CYC_POST :
                             (is_indexed || is_pc_rel) ? CYC_INDEX :
                             CYC_PLAIN;

    // correction by width and operand location
    wire       odd_ram   = (location == 3'(LOC_RAM_ODD));
    wire       ext_even  = (location == 3'(LOC_EXT_EVEN));
    wire       ext_slow  = (location == 3'(LOC_EXT_ODD)) || (location == 3'(LOC_EXT_NARROW));

    wire [2:0] corr_ram  = (width == 2'(WIDTH_BYTE)) ? 3'h0 :
                           (width == 2'(WIDTH_WORD)) ? 3'h1 : 3'h2;
    wire [2:0] corr_even = (width == 2'(WIDTH_LONG)) ? 3'h2 : 3'h1;

    wire [2:0] corr_slow = (width == 2'(WIDTH_BYTE)) ? 3'h1 :
                           (width == 2'(WIDTH_WORD)) ? 3'h3 : 3'h6;

    wire [2:0] correction = odd_ram ? corr_ram : ext_even ? corr_even :
                            ext_slow ? corr_slow : 3'h0;

    // totals
    wire [7:0] total_cycles = 8'(base_cycles) + 8'(mode_cycles) + 8'(correction);
    wire [3:0] total_length = 4'(base_bytes) + 4'(ext_bytes);

    // ========================================================
    // address forming; pointer arithmetic wraps in 16 bits
    wire [15:0] ptr_word  = pointer_reg[15:0];
    wire [15:0] idx_word  = pointer_reg[31:16];                                    // register seven

    wire [15:0] disp_full = disp_reg[15:0];
    wire [15:0] disp_short = {{8{disp_full[7]}}, disp_full[7:0]};

    wire [15:0] offset_word =
        is_short_displacement   ? 16'(ptr_word + disp_short) :
        is_long_displacement  ? 16'(ptr_word + disp_full) :
        is_indexed ? 16'(ptr_word + idx_word) :
        is_pc_rel  ? 16'(program_counter + disp_full) :
        is_direct  ? disp_full : ptr_word;
    wire [23:0] ea_next = {data_bank, offset_word};

    wire [2:0]  step    = (width == 2'(WIDTH_BYTE)) ? 3'h1 :
                          (width == 2'(WIDTH_WORD)) ? 3'h2 : 3'h4;

    wire [15:0] ptr_next = is_post_inc ? 16'(ptr_word + 16'(step)) : ptr_word;

    // short io form and short immediate extension, offered on read
    wire        io_hit   = ({16'h0000, disp_full[7:0]} <= IO_AREA_LAST);
    wire [15:0] imm_ext  = {{8{disp_reg[23]}}, disp_reg[23:16]};

    // ========================================================
    // accumulator update by width and transfer actions
    wire [15:0] low_old  = acc_reg[15:0];
    wire [7:0]  load_b   = operand_reg[7:0];

    wire [7:0]  hi_byte  = (low_act == 2'(LOW_ZERO)) ? 8'h00 :
                           (low_act == 2'(LOW_EXTEND)) ? {8{load_b[7]}} : low_old[15:8];
    wire [15:0] low_new  = (width == 2'(WIDTH_BYTE)) ? {hi_byte, load_b} :
                           operand_reg[15:0];

    wire [15:0] up_keep  = (width == 2'(WIDTH_LONG)) ? operand_reg[31:16] : acc_reg[31:16];
    wire [15:0] up_new   = (up_act == 2'(UP_COPY)) ? low_old :
                           (up_act == 2'(UP_ZERO)) ? 16'h0000 :
                           (up_act == 2'(UP_EXTEND)) ? {16{low_new[15]}} : up_keep;
    wire [31:0] acc_next = {up_new, low_new};

    // flag cells
    wire [6:0] flags_next;
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi = gi + 1) begin : g_flag
            flag_update u_flag (
                .action    (flags_reg[2*gi +: 2]),
                .old_value (flags_reg[14 + gi]),
                .result    (flags_reg[21 + gi]),
                .new_value (flags_next[gi])
            );
        end
    endgenerate

    // ========================================================
    // AXI4-Lite write channel: take address and data in either order
    logic       aw_held_reg;
    logic       w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // busy while b is out
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

    wire aw_take   = s_axi_awvalid && s_axi_awready;
    wire w_take    = s_axi_wvalid && s_axi_wready;
    wire aw_have   = aw_held_reg || aw_take;
    wire w_have    = w_held_reg || w_take;
    wire wr_fire   = aw_have && w_have;

    wire [7:0]  wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    wire wr_writable = (wr_addr == OFFSET_REQUEST) || (wr_addr == OFFSET_OPERAND) ||
                       (wr_addr == OFFSET_POINTER) || (wr_addr == OFFSET_DISP) ||
                       (wr_addr == OFFSET_ACC) || (wr_addr == OFFSET_REG_SEL);

    // a request write starts a decode one cycle later
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (nw & mask);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (aw_take && !wr_fire) aw_held_reg <= 1'b1;
            if (w_take && !wr_fire) w_held_reg <= 1'b1;
            if (aw_take) aw_addr_reg <= s_axi_awaddr;
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_writable ? 2'h0 : 2'h2;    // slverr on unmapped or read-only
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software register storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            request_reg <= '0;
            operand_reg <= 32'h00000000;
            pointer_reg <= 32'h00000000;
            disp_reg    <= 32'h00000000;
            acc_reg     <= 32'h00000000;
            flags_reg   <= 32'h00000000;
            go_reg      <= 1'b0;
        end else begin
            go_reg <= wr_fire && (wr_addr == OFFSET_REQUEST);

            if (wr_fire && wr_addr == OFFSET_REQUEST)
                request_reg <= REQUEST_BITS'(merge(32'(request_reg), wr_data, wr_mask));
            if (wr_fire && wr_addr == OFFSET_OPERAND)
                operand_reg <= merge(operand_reg, wr_data, wr_mask);
            if (wr_fire && wr_addr == OFFSET_POINTER)
                pointer_reg <= merge(pointer_reg, wr_data, wr_mask);
            if (wr_fire && wr_addr == OFFSET_DISP)
                disp_reg <= merge(disp_reg, wr_data, wr_mask);
            if (wr_fire && wr_addr == OFFSET_ACC)
                acc_reg <= merge(acc_reg, wr_data, wr_mask);
            if (wr_fire && wr_addr == OFFSET_REG_SEL)
                flags_reg <= merge(flags_reg, wr_data, wr_mask);
        end
    end

    // ========================================================
    // decode results and stall counter
    // results update only on go so software sees a stable snapshot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            address_reg   <= 24'h000000;
            acc_out_reg   <= 32'h00000000;
            ptr_out_reg   <= 16'h0000;
            counts_reg    <= 8'h00;
            length_reg    <= 4'h0;
            flags_out_reg <= 7'h00;
            mem_flag_reg  <= 1'b0;
            form_err_reg  <= 1'b0;
            stall_reg     <= 8'h00;
        end else if (go_reg) begin
            address_reg   <= is_reg_direct ? 24'h000000 : ea_next;
            acc_out_reg   <= acc_next;
            ptr_out_reg   <= ptr_next;
            counts_reg    <= total_cycles;
            length_reg    <= total_length;
            flags_out_reg <= flags_next;
            mem_flag_reg  <= !is_reg_direct;
            form_err_reg  <= form_error;
            stall_reg     <= total_cycles;
        end else if (stall_reg != 8'h00) begin
            stall_reg <= 8'(stall_reg - 8'h01);
        end
    end

    // outputs from flops
    assign operand_address = address_reg;
    assign stall_request   = (stall_reg != 8'h00);

    // ========================================================
    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_take = s_axi_arvalid && s_axi_arready;

    wire [31:0] rd_value =
        (s_axi_araddr == OFFSET_REQUEST) ? 32'(request_reg) :
        (s_axi_araddr == OFFSET_OPERAND) ? operand_reg :
        (s_axi_araddr == OFFSET_POINTER) ? pointer_reg :
        (s_axi_araddr == OFFSET_DISP)    ? disp_reg :
        (s_axi_araddr == OFFSET_ACC)     ? acc_reg :
        (s_axi_araddr == OFFSET_ADDRESS) ? {8'h00, address_reg} :
        (s_axi_araddr == OFFSET_COUNTS)  ? {imm_ext, 1'b0, io_hit, form_err_reg, mem_flag_reg,
                                            length_reg, counts_reg} :
        (s_axi_araddr == OFFSET_ACC_OUT) ? acc_out_reg :
        (s_axi_araddr == OFFSET_PTR_OUT) ? {6'h00, flags_out_reg, reg_number, ptr_out_reg} :
        (s_axi_araddr == OFFSET_REG_SEL) ? flags_reg : 32'h00000000;

    wire rd_mapped = (s_axi_araddr <= OFFSET_REG_SEL) && (s_axi_araddr[1:0] == 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_mapped ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // effective_address_decoder

// ---- core/ea_decoder_pkg.sv ----
// package for the effective address decoder: codes, widths, cycle counts
// assumes nothing of its surroundings beyond a single machine clock
package ea_decoder_pkg;

    // ========================================================
    // register map of the AXI4-Lite slave
    localparam logic [7:0] OFFSET_REQUEST  = 8'h00;
    localparam logic [7:0] OFFSET_OPERAND  = 8'h04;
    localparam logic [7:0] OFFSET_POINTER  = 8'h08;
    localparam logic [7:0] OFFSET_DISP     = 8'h0C;
    localparam logic [7:0] OFFSET_ACC      = 8'h10;
    localparam logic [7:0] OFFSET_ADDRESS  = 8'h14;
    localparam logic [7:0] OFFSET_COUNTS   = 8'h18;
    localparam logic [7:0] OFFSET_ACC_OUT  = 8'h1C;
    localparam logic [7:0] OFFSET_PTR_OUT  = 8'h20;
    localparam logic [7:0] OFFSET_REG_SEL  = 8'h24;

    // ========================================================
    // request register fields
    localparam int CODE_LSB      = 0;  // 5-bit addressing code
    localparam int WIDTH_LSB     = 5;  // 2-bit operand width
    localparam int LOCATION_LSB  = 7;  // 3-bit operand location
    localparam int BASE_LSB      = 10; // 4-bit listed base cycles
    localparam int BASE_LEN_LSB  = 14; // 3-bit listed base bytes
    localparam int LOW_ACT_LSB   = 17; // 2-bit bits 15..8 action
    localparam int UPPER_ACT_LSB = 19; // 2-bit upper word action
    localparam int FORM_LSB      = 21; // 1: register form, 0: memory form
    localparam int REQUEST_BITS  = 22;

    // ========================================================
    // addressing code boundaries
    localparam logic [4:0] CODE_REG_LAST  = 5'h07;
    localparam logic [4:0] CODE_IND_LAST  = 5'h0B;
    localparam logic [4:0] CODE_POST_LAST = 5'h0F;
    localparam logic [4:0] CODE_D8_LAST   = 5'h17;
    localparam logic [4:0] CODE_D16_LAST  = 5'h1B;
    localparam logic [4:0] CODE_IDX0      = 5'h1C;
    localparam logic [4:0] CODE_IDX1      = 5'h1D;
    localparam logic [4:0] CODE_PC_REL    = 5'h1E;
    localparam logic [4:0] CODE_DIRECT    = 5'h1F;

    // extension bytes and addressing cycles per form
    localparam logic [2:0] EXT_NONE = 3'h0;
    localparam logic [2:0] EXT_ONE  = 3'h1;
    localparam logic [2:0] EXT_TWO  = 3'h2;
    localparam logic [3:0] CYC_PLAIN = 4'h1;
    localparam logic [3:0] CYC_POST  = 4'h4;
    localparam logic [3:0] CYC_INDEX = 4'h2;

    // io area upper bound for the short io form
    localparam logic [23:0] IO_AREA_LAST = 24'h0000FF;

    typedef enum logic [1:0] { WIDTH_BYTE, WIDTH_WORD, WIDTH_LONG, WIDTH_SPARE } width_type;
    typedef enum logic [2:0] { LOC_REGISTER, LOC_RAM_EVEN, LOC_RAM_ODD, LOC_EXT_EVEN,
                               LOC_EXT_ODD, LOC_EXT_NARROW, LOC_SPARE6, LOC_SPARE7 } location_type;
    typedef enum logic [1:0] { LOW_NONE, LOW_ZERO, LOW_EXTEND, LOW_SPARE } low_action_type;
    typedef enum logic [1:0] { UP_NONE, UP_COPY, UP_ZERO, UP_EXTEND } upper_action_type;
    typedef enum logic [1:0] { FLAG_RESULT, FLAG_KEEP, FLAG_SET, FLAG_CLEAR } flag_action_type;

    // flag vector bit order: interrupt, stack, sticky, negative, zero, overflow, carry
    localparam int FLAG_COUNT = 7;

endpackage

// ---- core/flag_update.sv ----
// one flag update cell: picks new flag value from its action code
// assumes action and result come from the same clock domain
`timescale 1ns/1ps
module flag_update (
    input  wire logic [1:0] action,     // flag action code
    input  wire logic       old_value,  // flag before the instruction
    input  wire logic       result,     // flag as computed from the result
    output logic            new_value   // flag after the instruction
);
    import ea_decoder_pkg::*;

    // result, keep, force set, force clear
    assign new_value = (action == 2'(FLAG_RESULT)) ? result :
                       (action == 2'(FLAG_KEEP))   ? old_value :
                       (action == 2'(FLAG_SET));
endmodule // flag_update

// ---- tb/ead_monitor.sv ----
// checker for the decoder: bus handshakes, stall and address ports
// assumes a bind to the decoder top, every port matched by name
`timescale 1ns/1ps
module ead_monitor (
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, // handshakes
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,    // write side
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,  // read side
    input wire logic        stall_request,                               // stall level
    input wire logic [1:0]  s_axi_rresp,                                 // read response
    input wire logic [31:0] s_axi_rdata,                                 // read data
    input wire logic [23:0] operand_address                              // memory address
);
    // ========================================
    // one clock domain, so one default for all
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    aw_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("aw taken early");
    slverr_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read data");
    // reset must win even though the default disables on it
    reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
        && !stall_request && operand_address == 24'h0) else $error("reset left state");
    stall_rise_a: assert property ($rose(stall_request) |-> $past(s_axi_bvalid))
        else $error("stall without request");
    stall_bound_a: assert property ($rose(stall_request) |-> ##[1:30] !stall_request)
        else $error("stall too long");
endmodule // ead_monitor

// ---- tb/fetch_model.sv ----
// fetch side model: bank and counter of the instruction being decoded
// assumes the bench changes the set values only between instructions
`timescale 1ns/1ps
module fetch_model (
    input  wire logic        aclk,            // machine clock
    input  wire logic [7:0]  bank_set,        // bank wanted next
    input  wire logic [15:0] pc_set,          // counter wanted next
    output logic      [7:0]  data_bank,       // bank seen by decoder
    output logic      [15:0] program_counter  // counter seen by decoder
);
    // registered, so nothing moves in the edge that takes a request
    always_ff @(posedge aclk) begin
        data_bank       <= bank_set;
        program_counter <= pc_set;
    end
endmodule // fetch_model

// ---- tb/tb.sv ----
// bench: random decode requests over the register bus, checked by functions
// assumes the decoder package and a 200 MHz machine clock
`timescale 1ns/1ps
module tb;
    import ea_decoder_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, stall_request, f;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, bank_set = 0, data_bank;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, p, q, e;
    logic [3:0] s_axi_wstrb = 4'hF, base;
    logic [1:0] s_axi_bresp, s_axi_rresp, w, r;
    logic [15:0] pc_set = 0, program_counter;
    logic [23:0] operand_address, d;
    logic [2:0] l, bl;
    logic [4:0] c;
    int num_errors = 0, n_tests = 0, cyc = 0, seed = 88;
    effective_address_decoder dut_u (.*);
    fetch_model fm_u (.*);
    always #2.5 aclk = ~aclk;
    // ========================================
    // bus tasks: ready is sampled at the negedge, released after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] o);
        logic ta, tw, done;
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk); ta = s_axi_awready; tw = s_axi_wready; done = s_axi_bvalid;
            o = s_axi_bresp;
            @(posedge aclk); if (ta) s_axi_awvalid <= 1'b0; if (tw) s_axi_wvalid <= 1'b0;
        end while (!done);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
        logic ta, done;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk); ta = s_axi_arready; done = s_axi_rvalid; v = s_axi_rdata;
            o = s_axi_rresp;
            @(posedge aclk); if (ta) s_axi_arvalid <= 1'b0;
        end while (!done);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin num_errors++; $display("Error %s expected %h seen %h", n, e, g); end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // expectations: mode cycles, extension bytes, correction, address, acc, flags
    function automatic logic [3:0] mode_cyc(input logic [4:0] k);
        if (k < 5'h08) return 0;
        if (k >= 5'h0C && k <= 5'h0F) return 4;
        return (k >= 5'h1C && k <= 5'h1E) ? 2 : 1;
    endfunction
    function automatic logic [3:0] ext_len(input logic [4:0] k);
        if (k < 5'h10 || k == 5'h1C || k == 5'h1D) return 0;
        return (k < 5'h18) ? 1 : 2;
    endfunction
    function automatic logic [3:0] corr(input logic [2:0] m, input logic [1:0] z);
        case (m)
            3'h2: return (z == 0) ? 0 : (z == 1) ? 1 : 2;
            3'h3: return (z == 2) ? 2 : 1;
            3'h4, 3'h5: return (z == 0) ? 1 : (z == 1) ? 3 : 6;
            default: return 0;
        endcase
    endfunction
    function automatic logic [15:0] ea_off(input logic [4:0] k, input logic [15:0] pcv);
        if (k < 5'h10) return p[15:0];
        if (k < 5'h18) return p[15:0] + {{8{d[7]}}, d[7:0]};
        if (k < 5'h1C) return p[15:0] + d[15:0];
        if (k < 5'h1E) return p[15:0] + p[31:16];
        return (k == 5'h1E) ? pcv + d[15:0] : d[15:0];
    endfunction
    function automatic logic [31:0] acc_exp();
        logic [15:0] lo;
        lo = w ? rv[15:0] : {rv[21:20] == 1 ? 8'h0 : rv[21:20] == 2 ? {8{rv[7]}} : p[15:8],
                             rv[7:0]};
        return {rv[23:22] == 1 ? p[15:0] : rv[23:22] == 2 ? 16'h0 : rv[23:22] == 3 ?
                {16{lo[15]}} : w == 2 ? rv[31:16] : p[31:16], lo};
    endfunction
    function automatic logic [6:0] flg(input logic [31:0] v);
        for (int k = 0; k < 7; k++)
            flg[k] = v[2*k+:2] == 2 || v[2*k+:2] == 0 && v[21+k] || v[2*k+:2] == 1 && v[14+k];
    endfunction
    // a hang counts as a mismatch; the whole run needs about 1300 cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin num_errors++; complete_run; end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // every code twice; second pass puts the pointer at FFFF to force wrap
        for (int i = 0; i < 64; i++) begin
            c = i[4:0]; rv = $random(seed); p = $random(seed); d = $random(seed);
            w = rv[1:0] % 2'h3; l = rv[4:2] % 3'h6; f = rv[5]; base = {2'b0, rv[7:6]};
            bl = rv[10:8]; bank_set <= rv[19:12]; pc_set <= rv[31:16];
            if (i[5]) p[15:0] = 16'hFFFF;
            wr(OFFSET_POINTER, p, r);
            wr(OFFSET_DISP, {8'h0, d}, r);
            wr(OFFSET_OPERAND, rv, r);
            wr(OFFSET_ACC, p, r);
            wr(OFFSET_REG_SEL, p ^ rv, r);
            wr(OFFSET_REQUEST, {10'h0, f, rv[23:20], bl, base, l, w, c}, r);
            chk("wr_resp", 2'h0, r);
            rd(OFFSET_COUNTS, q, r);
            chk("cycles", base + mode_cyc(c) + corr(l, w), q[7:0]);
            chk("length", bl + ext_len(c), q[11:8]);
            chk("memory", c > 5'h07, q[12]);
            chk("form_err", f ? c > 5'h07 : c < 5'h08, q[13]);
            chk("short_imm", {{8{d[23]}}, d[23:16]}, q[31:16]);
            e = c < 5'h08 ? 0 : {bank_set, ea_off(c, pc_set)};
            rd(OFFSET_ADDRESS, q, r);
            chk("address", e, q);
            chk("ea_port", e, operand_address);
            rd(OFFSET_PTR_OUT, q, r);
            if (c < 5'h08) chk("reg_num", w == 2 ? c >> 1 : c[2:0], q[18:16]);
            if (c >= 5'h0C && c <= 5'h0F) chk("post_inc", 16'(p + (1 << w)), q[15:0]);
            chk("flags", flg(p ^ rv), q[25:19]);
            rd(OFFSET_ACC_OUT, q, r);
            chk("acc", acc_exp(), q);
        end
        wr(OFFSET_ADDRESS, 32'h0, r);
        chk("ro_resp", 2'h2, r);
        rd(8'h3C, q, r);
        chk("bad_resp", 2'h2, r);
        complete_run;
    end
endmodule // tb
bind effective_address_decoder ead_monitor mon_u (.*);
